// [strobe_gen_pkg.sv]
package strobe_gen_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ             = 20_000_000;
  localparam int unsigned CYCLES_PER_US      = CLK_HZ / 1_000_000;
  localparam int unsigned STROBE_SPACING_US  = 9_000;  // 9 ms between strobes
  localparam int unsigned STROBE_WIDTH_US    = 50;     // low time of one strobe
  localparam int unsigned DEBOUNCE_US        = 5_000;  // step button settle time
  localparam int unsigned STROBE_SPACING_CYC = STROBE_SPACING_US * CYCLES_PER_US;
  localparam int unsigned OSC_HALF_CYC       = STROBE_SPACING_CYC / 2;
  localparam int unsigned STROBE_WIDTH_CYC   = STROBE_WIDTH_US * CYCLES_PER_US;
  localparam int unsigned DEBOUNCE_CYC       = DEBOUNCE_US * CYCLES_PER_US;

  // widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CODE_W = 7;
  localparam int unsigned CNT_W  = 20;

  // register map (byte addresses)
  localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;

  // control field positions
  localparam int unsigned CTRL_CODE_LSB  = 0;
  localparam int unsigned CTRL_RECV_BIT  = 8;
  localparam int unsigned CTRL_MODE_LSB  = 9;
  localparam int unsigned CTRL_PDET_BIT  = 11;

  // status field positions
  localparam int unsigned STAT_STROBE_BIT = 0;
  localparam int unsigned STAT_METER_BIT  = 1;
  localparam int unsigned STAT_ARMED_BIT  = 2;
  localparam int unsigned STAT_GATE_BIT   = 3;
  localparam int unsigned STAT_PWRIN_BIT  = 4;
  localparam int unsigned STAT_BTN_BIT    = 5;
  localparam int unsigned STAT_DATA_LSB   = 8;
  localparam int unsigned STAT_COUNT_LSB  = 16;

  // reset values
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_007f;  // all marks, off

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_REPEAT,
    MODE_MANUAL,
    MODE_SPARE
  } strobe_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0]   awaddr;
    logic                awvalid;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W/8-1:0] wstrb;
    logic                wvalid;
    logic                bready;
    logic [ADDR_W-1:0]   araddr;
    logic                arvalid;
    logic                rready;
  } axi_req_t;

  typedef struct packed {
    logic                awready;
    logic                wready;
    logic [1:0]          bresp;
    logic                bvalid;
    logic                arready;
    logic [DATA_W-1:0]   rdata;
    logic [1:0]          rresp;
    logic                rvalid;
  } axi_rsp_t;

endpackage

// [strobe_gen.sv]
module strobe_gen
  import strobe_gen_pkg::*;
#(
  parameter int unsigned OSC_HALF = OSC_HALF_CYC,
  parameter int unsigned DEBOUNCE = DEBOUNCE_CYC
) (
  input  wire logic                         clock,
  input  wire logic                         nrst,
  input  wire strobe_gen_pkg::axi_req_t     axi_req,
  output strobe_gen_pkg::axi_rsp_t          axi_rsp,
  input  wire logic [strobe_gen_pkg::CODE_W-1:0] data_i,
  output logic [strobe_gen_pkg::CODE_W-1:0] data_o,
  output logic [strobe_gen_pkg::CODE_W-1:0] data_oe_n,
  input  wire logic                         power_on_i,
  output logic                              power_on_o,
  output logic                              power_on_oe_n,
  output logic                              strobe_mode_select_n,
  input  wire logic                         step_button_n,
  input  wire logic                         probe_in,
  output logic                              meter_out
);
  import strobe_gen_pkg::*;

  // saturating-free counter step, used by several timers
  function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] v);
    count_up = v + 20'h00001;
  endfunction

  // true once a counter has reached a limit
  function automatic logic reached(input logic [CNT_W-1:0] v, input int unsigned lim);
    reached = (v >= CNT_W'(lim - 1));
  endfunction

  logic [DATA_W-1:0] ctrl_q;
  logic [CODE_W-1:0] code_level;
  logic              receive_message_control;
  strobe_mode_t      strobe_mode_select;
  logic              pulse_detect_en;

  assign code_level              = ctrl_q[CTRL_CODE_LSB +: CODE_W];
  assign receive_message_control = ctrl_q[CTRL_RECV_BIT];
  assign strobe_mode_select      = strobe_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign pulse_detect_en         = ctrl_q[CTRL_PDET_BIT];

  // axi4-lite slave
  logic              aw_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic              w_held_q;
  logic [DATA_W-1:0] w_data_q;
  logic [3:0]        w_strb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_q;
  logic              do_write;
  logic              aw_take;
  logic              w_take;
  logic              ar_take;
  logic [DATA_W-1:0] status_word;

  // ready while nothing is held and no response is pending
  assign aw_take  = axi_req.awvalid && !aw_held_q && !bvalid_q;
  assign w_take   = axi_req.wvalid && !w_held_q && !bvalid_q;
  assign ar_take  = axi_req.arvalid && !rvalid_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  always_comb begin
    axi_rsp         = '0;
    axi_rsp.awready = !aw_held_q && !bvalid_q;
    axi_rsp.wready  = !w_held_q && !bvalid_q;
    axi_rsp.bvalid  = bvalid_q;
    axi_rsp.bresp   = bresp_q;
    axi_rsp.arready = !rvalid_q;
    axi_rsp.rvalid  = rvalid_q;
    axi_rsp.rdata   = rdata_q;
    axi_rsp.rresp   = rresp_q;
  end

  // capture write address
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (aw_take) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= axi_req.awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  // capture write data
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (w_take) begin
      w_held_q <= 1'b1;
      w_data_q <= axi_req.wdata;
      w_strb_q <= axi_req.wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (aw_addr_q[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2] ||
                   aw_addr_q[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2])
                  ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && axi_req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // control register, byte lanes honoured; software picks the mode
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RESET;
    end else if (do_write && aw_addr_q[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2]) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_q[b]) begin
          ctrl_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
        end
      end
    end
  end

  // read channel, answer one cycle after address accepted
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      if (axi_req.araddr[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2]) begin
        rdata_q <= ctrl_q;
        rresp_q <= RESP_OKAY;
      end else if (axi_req.araddr[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2]) begin
        rdata_q <= status_word;
        rresp_q <= RESP_OKAY;
      end else begin
        rdata_q <= '0;
        rresp_q <= RESP_SLVERR;
      end
    end else if (rvalid_q && axi_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // free-running oscillator, one tick per half strobe spacing
  logic [CNT_W-1:0] osc_cnt_q;
  logic             osc_tick;

  assign osc_tick = reached(osc_cnt_q, OSC_HALF);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      osc_cnt_q <= '0;
    end else if (osc_tick) begin
      osc_cnt_q <= '0;
    end else begin
      osc_cnt_q <= count_up(osc_cnt_q);
    end
  end

  // step button: synchroniser and debounce
  logic             btn_meta_q;
  logic             btn_sync_q;
  logic             btn_stable_q;
  logic [CNT_W-1:0] btn_cnt_q;
  logic             btn_release;

  // two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      btn_meta_q <= 1'b1;
      btn_sync_q <= 1'b1;
    end else begin
      btn_meta_q <= step_button_n;
      btn_sync_q <= btn_meta_q;
    end
  end

  // accept a new level only after it has held for the debounce time
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      btn_stable_q <= 1'b1;
      btn_cnt_q    <= '0;
    end else if (btn_sync_q == btn_stable_q) begin
      btn_cnt_q <= '0;
    end else if (reached(btn_cnt_q, DEBOUNCE)) begin
      btn_stable_q <= btn_sync_q;
      btn_cnt_q    <= '0;
    end else begin
      btn_cnt_q <= count_up(btn_cnt_q);
    end
  end

  // release is the debounced pressed-to-released step
  assign btn_release = (btn_sync_q && !btn_stable_q) && reached(btn_cnt_q, DEBOUNCE);

  // gate flop, manual arm and strobe timer
  logic             gate_q;      // high means inhibited
  logic             armed_q;
  logic             strobe_q;
  logic [CNT_W-1:0] width_cnt_q;
  logic             strobe_start;
  logic             strobe_end;
  logic [15:0]      strobe_count_q;

  assign strobe_end = strobe_q && reached(width_cnt_q, STROBE_WIDTH_CYC);

  // strobe begins on an oscillator tick that finds the gate open in repeat mode or the arm set in manual mode
  always_comb begin
    strobe_start = 1'b0;
    unique case (strobe_mode_select)
      MODE_REPEAT: strobe_start = osc_tick && !gate_q && !strobe_q;
      MODE_MANUAL: strobe_start = osc_tick && armed_q && !strobe_q;
      default:     strobe_start = 1'b0;
    endcase
  end

  // gate flop: forced set outside repeat mode, toggles per tick in repeat
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gate_q <= 1'b1;
    end else if (strobe_mode_select != MODE_REPEAT) begin
      gate_q <= 1'b1;
    end else if (osc_tick) begin
      gate_q <= !gate_q;
    end
  end

  // manual arm: set on button release, cleared when the strobe ends
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      armed_q <= 1'b0;
    end else if (strobe_mode_select != MODE_MANUAL) begin
      armed_q <= 1'b0;
    end else if (btn_release) begin
      armed_q <= 1'b1;
    end else if (strobe_end) begin
      armed_q <= 1'b0;
    end
  end

  // strobe width timer
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strobe_q    <= 1'b0;
      width_cnt_q <= '0;
    end else if (strobe_start) begin
      strobe_q    <= 1'b1;
      width_cnt_q <= '0;
    end else if (strobe_end) begin
      strobe_q <= 1'b0;
    end else if (strobe_q) begin
      width_cnt_q <= count_up(width_cnt_q);
    end
  end

  // count of strobes issued, visible in status
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strobe_count_q <= '0;
    end else if (strobe_start) begin
      strobe_count_q <= strobe_count_q + 16'h0001;
    end
  end

  // active-low strobe, idles high
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strobe_mode_select_n <= 1'b1;
    end else begin
      strobe_mode_select_n <= !(strobe_start || (strobe_q && !strobe_end));
    end
  end

  // data lines and power-on closure
  // a space drives low, a mark releases the line; value held by ctrl_q
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      data_o    <= '0;
      data_oe_n <= '1;
    end else begin
      data_o    <= '0;
      data_oe_n <= code_level;
    end
  end

  // ground the power-on line while receive message is on
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      power_on_o    <= 1'b0;
      power_on_oe_n <= 1'b1;
    end else begin
      power_on_o    <= 1'b0;
      power_on_oe_n <= !receive_message_control;
    end
  end

  // pulse detect
  logic probe_q;
  logic meter_q;

  // rising edge of the probe toggles the meter flop
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      probe_q <= 1'b0;
      meter_q <= 1'b0;
    end else begin
      probe_q <= probe_in;
      if (pulse_detect_en && probe_in && !probe_q) begin
        meter_q <= !meter_q;
      end
    end
  end

  // meter holds the flop level between pulses
  assign meter_out = meter_q;

  // status word
  always_comb begin
    status_word                                  = '0;
    status_word[STAT_STROBE_BIT]                 = strobe_q;
    status_word[STAT_METER_BIT]                  = meter_q;
    status_word[STAT_ARMED_BIT]                  = armed_q;
    status_word[STAT_GATE_BIT]                   = gate_q;
    status_word[STAT_PWRIN_BIT]                  = power_on_i;
    status_word[STAT_BTN_BIT]                    = btn_stable_q;
    status_word[STAT_DATA_LSB +: CODE_W]         = data_i;
    status_word[STAT_COUNT_LSB +: 16]            = strobe_count_q;
  end

endmodule // strobe_gen

// [strobe_gen_chk.sv]
module strobe_gen_chk
  import strobe_gen_pkg::*;
#(
  parameter int unsigned OSC_HALF = OSC_HALF_CYC
) (
  input wire logic                     clock,
  input wire logic                     nrst,
  input wire strobe_gen_pkg::axi_req_t axi_req,
  input wire strobe_gen_pkg::axi_rsp_t axi_rsp,
  input wire logic [CODE_W-1:0]        data_o,
  input wire logic [CODE_W-1:0]        data_oe_n,
  input wire logic                     power_on_o,
  input wire logic                     power_on_oe_n,
  input wire logic                     strobe_mode_select_n,
  input wire logic                     probe_in,
  input wire logic                     meter_out
);
  logic [DATA_W-1:0] ctrl_q;
  logic [2:0]        age_q;
  logic [19:0]       lo_q;
  logic [19:0]       gap_q;
  logic              rep_ok_q;
  logic              pin_q;
  logic              rise1_q;
  logic              rise2_q;
  logic              wr_ctrl;

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // control word taken on the bus
  assign wr_ctrl = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
                   && axi_req.awaddr == CTRL_OFFSET;

  // mirror of control word and its age
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RESET;
      age_q  <= '0;
    end else if (wr_ctrl) begin
      ctrl_q <= axi_req.wdata;
      age_q  <= '0;
    end else if (age_q != 3'd7) begin
      age_q <= age_q + 3'd1;
    end
  end

  // strobe low time, spacing and probe edges
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lo_q     <= '0;
      gap_q    <= '0;
      rep_ok_q <= 1'b0;
      pin_q    <= 1'b0;
      rise1_q  <= 1'b0;
      rise2_q  <= 1'b0;
    end else begin
      lo_q     <= strobe_mode_select_n ? 20'd0 : lo_q + 20'd1;
      gap_q    <= $fell(strobe_mode_select_n) ? 20'd1 : gap_q + 20'd1;
      rep_ok_q <= wr_ctrl ? 1'b0 : ($fell(strobe_mode_select_n) ?
                  (ctrl_q[10:9] == 2'd1 && age_q == 3'd7) : rep_ok_q);
      pin_q    <= probe_in;
      rise1_q  <= probe_in && !pin_q;
      rise2_q  <= rise1_q;
    end
  end

  a_code_lines: assert property (age_q == 3'd7 |-> data_oe_n == ctrl_q[6:0] && data_o == '0)
    else $error("code lines do not follow control");
  a_power_line: assert property (age_q == 3'd7 |-> power_on_oe_n == !ctrl_q[8] && !power_on_o)
    else $error("power-on line does not follow control");
  a_strobe_width: assert property ($rose(strobe_mode_select_n) |-> lo_q == STROBE_WIDTH_CYC)
    else $error("strobe width wrong");
  a_strobe_spacing: assert property ($fell(strobe_mode_select_n) && rep_ok_q |-> gap_q == 2 * OSC_HALF)
    else $error("repeat spacing wrong");
  a_off_quiet: assert property ((ctrl_q[10:9] == 2'd0 || ctrl_q[10:9] == 2'd3) && age_q == 3'd7
    && strobe_mode_select_n |=> strobe_mode_select_n)
    else $error("strobe in off mode");
  a_meter_toggle: assert property ($rose(probe_in) && ctrl_q[11] && age_q == 3'd7
    |-> ##[1:2] $changed(meter_out))
    else $error("meter did not toggle");
  a_meter_rest: assert property ($changed(meter_out) |-> rise1_q || rise2_q)
    else $error("meter moved without pulse");
  a_strobe_high_in_reset: assert property ($rose(nrst) |-> strobe_mode_select_n && data_oe_n == 7'h7f)
    else $error("outputs not at rest after reset");

  c_repeat: cover property ($fell(strobe_mode_select_n) && rep_ok_q);
  c_manual: cover property ($fell(strobe_mode_select_n) && ctrl_q[10:9] == 2'd2);
  c_meter:  cover property ($changed(meter_out));
endmodule // strobe_gen_chk

bind strobe_gen strobe_gen_chk #(.OSC_HALF(OSC_HALF)) chk (
  .clock(clock), .nrst(nrst), .axi_req(axi_req), .axi_rsp(axi_rsp), .data_o(data_o),
  .data_oe_n(data_oe_n), .power_on_o(power_on_o), .power_on_oe_n(power_on_oe_n),
  .strobe_mode_select_n(strobe_mode_select_n), .probe_in(probe_in), .meter_out(meter_out));

// [printer_model.sv]
module printer_model
  import strobe_gen_pkg::*;
(
  input  wire logic [CODE_W-1:0] data_o,
  input  wire logic [CODE_W-1:0] data_oe_n,
  input  wire logic              power_on_o,
  input  wire logic              power_on_oe_n,
  input  wire logic              strobe_mode_select_n,
  output logic [CODE_W-1:0]      data_i,
  output logic                   power_on_i,
  output logic [CODE_W-1:0]      got_char,
  output logic [15:0]            n_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [CODE_W-1:0] char_q = '0;
  logic [15:0]       cnt_q  = '0;

  // released lines sit at the pull-up level
  assign data_i     = data_o | data_oe_n;
  assign power_on_i = power_on_o | power_on_oe_n;
  assign got_char   = char_q;
  assign n_strobe   = cnt_q;

  // print only on a falling strobe with high voltage on
  always @(negedge strobe_mode_select_n) begin
    if (!power_on_i) begin
      char_q <= data_i;
      cnt_q  <= cnt_q + 16'd1;
    end
  end
endmodule // printer_model

// [strobe_gen_bench.sv]
module strobe_gen_bench
  import strobe_gen_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned PER = 2400;
  logic              clock, nrst, step_button_n, probe_in;
  axi_req_t          axi_req;
  axi_rsp_t          axi_rsp;
  logic [CODE_W-1:0] data_i, data_o, data_oe_n, got_char;
  logic              power_on_i, power_on_o, power_on_oe_n, strobe_mode_select_n, meter_out, m0;
  logic [15:0]       n_strobe;
  logic [DATA_W-1:0] rq[$], mq[$], v;
  logic [1:0]        bq[$], rrq[$];
  int                n_mismatch, check_count, n0, k, np;

  strobe_gen #(.OSC_HALF(PER / 2), .DEBOUNCE(4)) dut (.clock(clock), .nrst(nrst),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .data_i(data_i), .data_o(data_o),
    .data_oe_n(data_oe_n), .power_on_i(power_on_i), .power_on_o(power_on_o),
    .power_on_oe_n(power_on_oe_n), .strobe_mode_select_n(strobe_mode_select_n),
    .step_button_n(step_button_n), .probe_in(probe_in), .meter_out(meter_out));
  printer_model prn (.data_o(data_o), .data_oe_n(data_oe_n), .power_on_o(power_on_o),
    .power_on_oe_n(power_on_oe_n), .strobe_mode_select_n(strobe_mode_select_n), .data_i(data_i),
    .power_on_i(power_on_i), .got_char(got_char), .n_strobe(n_strobe));

  // clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, logic [1:0] r);
    logic aw, w, b;
    bq.push_back(r);
    b = 1'b0;
    @(posedge clock);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    while (!b) begin
      @(negedge clock);
      aw = axi_req.awvalid && axi_rsp.awready;
      w = axi_req.wvalid && axi_rsp.wready;
      b = axi_rsp.bvalid;
      @(posedge clock);
      if (aw) axi_req.awvalid <= 1'b0;
      if (w) axi_req.wvalid <= 1'b0;
      if (b) axi_req.bready <= 1'b0;
    end
  endtask

  task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e, logic [DATA_W-1:0] m);
    logic ar, r;
    rq.push_back(e);
    mq.push_back(m);
    rrq.push_back((a == CTRL_OFFSET || a == STATUS_OFFSET) ? RESP_OKAY : RESP_SLVERR);
    r = 1'b0;
    @(posedge clock);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    while (!r) begin
      @(negedge clock);
      ar = axi_req.arvalid && axi_rsp.arready;
      r = axi_rsp.rvalid;
      @(posedge clock);
      if (ar) axi_req.arvalid <= 1'b0;
      if (r) axi_req.rready <= 1'b0;
    end
  endtask

  // bouncy press and release of the step button
  task automatic press();
    repeat (2) begin
      step_button_n <= 1'b0;
      @(posedge clock);
      step_button_n <= 1'b1;
      @(posedge clock);
    end
    step_button_n <= 1'b0;
    repeat (20) @(posedge clock);
    step_button_n <= 1'b1;
    @(posedge clock);
    step_button_n <= 1'b0;
    @(posedge clock);
    step_button_n <= 1'b1;
  endtask

  task automatic close_out();
    $display("TB: checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // response monitor takes the oldest expectation
  always @(negedge clock) begin
    if (axi_rsp.rvalid && axi_req.rready && rq.size() > 0) begin
      check("read data", rq.pop_front(), axi_rsp.rdata & mq.pop_front());
      check("read resp", {30'h0, rrq.pop_front()}, {30'h0, axi_rsp.rresp});
    end
    if (axi_rsp.bvalid && axi_req.bready && bq.size() > 0)
      check("write resp", {30'h0, bq.pop_front()}, {30'h0, axi_rsp.bresp});
  end

  // watchdog
  initial begin
    repeat (80000) @(posedge clock);
    n_mismatch++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    close_out();
  end

  initial begin
    nrst = 1'b0;
    axi_req = '0;
    step_button_n = 1'b1;
    probe_in = 1'b0;
    void'($urandom(32'h853f));
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    check("code lines", 32'h7f, {25'h0, data_oe_n});
    rd(CTRL_OFFSET, CTRL_RESET, '1);
    // random characters with and without receive message
    for (k = 0; k < 4; k++) begin
      v = $urandom & 32'h17f;
      wr(CTRL_OFFSET, v, RESP_OKAY);
      repeat (3) @(posedge clock);
      rd(STATUS_OFFSET, {17'h0, v[6:0], 3'h0, ~v[8], 4'h0}, 32'h7f10);
    end
    $display("TB: test lines done");
    v = 32'h300 | ($urandom & 32'h7f);
    wr(CTRL_OFFSET, v, RESP_OKAY);
    n0 = n_strobe;
    for (k = 0; k < 4 * PER && n_strobe < n0 + 3; k++) @(negedge clock);
    check("repeat count", 32'(n0 + 3), {16'h0, n_strobe});
    check("printed char", {25'h0, v[6:0]}, {25'h0, got_char});
    $display("TB: test repeat done");
    // off mode and the spare mode code that also means off
    for (k = 0; k < 2; k++) begin
      wr(CTRL_OFFSET, (k == 0) ? 32'h155 : 32'h755, RESP_OKAY);
      repeat (1100) @(posedge clock);
      n0 = n_strobe;
      press();
      repeat (3 * PER) @(posedge clock);
      check("off count", 32'(n0), {16'h0, n_strobe});
    end
    $display("TB: test off done");
    wr(CTRL_OFFSET, 32'h52a, RESP_OKAY);
    repeat (2 * PER) @(posedge clock);
    n0 = n_strobe;
    for (k = 1; k < 3; k++) begin
      press();
      repeat (2 * PER) @(posedge clock);
      check("manual count", 32'(n0 + k), {16'h0, n_strobe});
    end
    check("manual char", 32'h2a, {25'h0, got_char});
    $display("TB: test manual done");
    wr(CTRL_OFFSET, 32'h800, RESP_OKAY);
    repeat (3) @(posedge clock);
    m0 = meter_out;
    np = $urandom_range(9, 3);
    repeat (np) begin
      probe_in <= 1'b1;
      repeat (3) @(posedge clock);
      probe_in <= 1'b0;
      repeat (3) @(posedge clock);
    end
    repeat (50) @(posedge clock);
    check("meter", {31'h0, m0 ^ np[0]}, {31'h0, meter_out});
    $display("TB: test pulse done");
    wr(8'h08, $urandom, RESP_SLVERR);
    rd(8'h0c, 32'h0, '1);
    wr(STATUS_OFFSET, 32'hffff_ffff, RESP_OKAY);
    rd(CTRL_OFFSET, 32'h800, '1);
    $display("TB: test map done");
    wr(CTRL_OFFSET, 32'h300, RESP_OKAY);
    for (k = 0; k < 2 * PER && strobe_mode_select_n; k++) @(negedge clock);
    @(posedge clock);
    nrst <= 1'b0;
    #1;
    check("strobe in reset", 32'h1, {31'h0, strobe_mode_select_n});
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    rd(CTRL_OFFSET, CTRL_RESET, '1);
    $display("TB: test reset done");
    close_out();
  end
endmodule // strobe_gen_bench
